// >>> rtl/spp_pkg.sv
// Shared constants and types of the stepper pattern port
package spp_pkg;
    // Printed register indices; byte address is four times the index
    localparam logic [11:0] SPP_IDX_PAT_A   = 12'h04C;
    localparam logic [11:0] SPP_IDX_PAT_B   = 12'h04D;
    localparam logic [11:0] SPP_IDX_CTRL    = 12'h050;
    localparam logic [11:0] SPP_IDX_FUNC    = 12'h051;
    localparam logic [11:0] SPP_IDX_PDATA   = 12'h052;
    localparam logic [11:0] SPP_ADDR_PAT_A  = {SPP_IDX_PAT_A[9:0], 2'b00};
    localparam logic [11:0] SPP_ADDR_PAT_B  = {SPP_IDX_PAT_B[9:0], 2'b00};
    localparam logic [11:0] SPP_ADDR_CTRL   = {SPP_IDX_CTRL[9:0], 2'b00};
    localparam logic [11:0] SPP_ADDR_FUNC   = {SPP_IDX_FUNC[9:0], 2'b00};
    localparam logic [11:0] SPP_ADDR_PDATA  = {SPP_IDX_PDATA[9:0], 2'b00};

    // Pattern register field positions
    localparam int unsigned SPP_LATCH_LSB   = 4;
    localparam int unsigned SPP_ALT_LSB     = 0;

    // Values after reset
    localparam logic [3:0]  SPP_LATCH_RST   = 4'h0;
    localparam logic [8:0]  SPP_CTRL_RST    = 9'h000;
    localparam logic [7:0]  SPP_FUNC_RST    = 8'h00;
    localparam logic [7:0]  SPP_PDATA_RST   = 8'h00;

    // Channel A trigger source codes
    localparam logic [1:0]  SPP_TRIG_T0     = 2'h0;
    localparam logic [1:0]  SPP_TRIG_T1     = 2'h1;
    localparam logic [1:0]  SPP_TRIG_T5     = 2'h2;

    // Per-channel mode bits
    typedef struct packed {
        logic pattern_sel;                 // Pattern generation operation
        logic excite_sel;                  // 1 = 1-2 step ring, 0 = 1/2 step
        logic dir_reverse;                 // 1 = bit 3 toward bit 0
    } spp_chan_cfg_t;

    // Control register layout, bits 8..0
    typedef struct packed {
        logic          trig_b_sel;         // 0 = timer 4, 1 = timer 5
        logic [1:0]    trig_a_sel;         // Channel A trigger source
        spp_chan_cfg_t ch_b;               // Bits 5..3
        spp_chan_cfg_t ch_a;               // Bits 2..0
    } spp_ctrl_t;
endpackage

// >>> rtl/spp_top.sv
// Two-channel stepping motor / pattern generator on a shared 8-bit port
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

// Functional notes
// - Two independent 4-bit channels share one port
// - Channel A triggers from timer 0, 1 or 5
// - Control selects stepping or pattern operation
// - Channel A register: latch high, alternate low
// - Channel B register uses the same layout
// - Pattern operation blocks latch writes, keeps alternate
// - Pattern shifts like 1-2 step; reload before trigger (code rings only with excite_sel also set)
// - Function control picks pattern or port per pin
// - Latch shifts once per rising trigger edge
// - Direction 0 rotates upward, 1 rotates downward
// - Alternate nibble ignored in 1/2 step excitation
// - 1-2 step shifts latch and alternate as ring
// - 16-bit trigger only on upper compare match
module spp_top import spp_pkg::*; (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Timer triggers
    input  wire logic        timer_toggle_ff0_i,
    input  wire logic        timer_toggle_ff1_i,
    input  wire logic        toggle_invert_en_i,
    input  wire logic        compare_upper_a_match_i,
    input  wire logic        compare_upper_b_match_i,
    // Shared port
    output logic      [7:0]  shared_port_o
);

    spp_ctrl_t      pattern_control_reg;   // Mode, direction, trigger select
    logic [7:0]     port_func_ctrl_r;      // Per-pin pattern/port select
    logic [7:0]     port_data_r;           // Plain port data
    logic [3:0]     latch_r [2];           // Output latches
    logic [3:0]     alt_r   [2];           // Shift-alternate nibbles
    logic [3:0]     trig_prev_r;           // Trigger levels one cycle ago
    logic [3:0]     trig_src;              // Gated trigger sources
    logic [3:0]     trig_rise;             // Rising edges of sources
    logic [1:0]     step_trig;             // Per-channel shift strobe
    logic           trig_a_rise;           // Channel A selected edge
    logic [1:0]     wr_pat;                // Per-channel register write
    spp_chan_cfg_t  chan_cfg [2];          // Per-channel mode bits
    logic           setup_ph;              // APB setup cycle
    logic           wr_acc;                // APB write access edge
    logic           addr_ok;               // Address is mapped
    logic [31:0]    rd_mux;                // Read data for this address
    logic [7:0]     port_nxt;              // Next shared port value

    // Ring shift whenever excite_sel is set, stepping or pattern operation, {latch, alternate}
    function automatic logic [7:0] spp_ring_step(
        input logic [3:0] lat,
        input logic [3:0] alt,
        input logic       rev
    );
        logic [7:0] ring;
        logic [7:0] rot;
        ring = '0;
        rot  = '0;
        // Interleave so that ring bit 2i is alternate i, 2i+1 latch i
        for (int i = 0; i < 4; i++) begin
            ring[2*i]   = alt[i];
            ring[2*i+1] = lat[i];
        end
        rot = rev ? {ring[0], ring[7:1]} : {ring[6:0], ring[7]};
        spp_ring_step = '0;
        for (int i = 0; i < 4; i++) begin
            spp_ring_step[SPP_LATCH_LSB+i] = rot[2*i+1];
            spp_ring_step[SPP_ALT_LSB+i]   = rot[2*i];
        end
    endfunction

    // 4-bit rotation for 1-step and 2-step excitation
    function automatic logic [3:0] spp_rot4(
        input logic [3:0] lat,
        input logic       rev
    );
        spp_rot4 = rev ? {lat[0], lat[3:1]} : {lat[2:0], lat[3]};
    endfunction

    assign chan_cfg[0] = pattern_control_reg.ch_a;
    assign chan_cfg[1] = pattern_control_reg.ch_b;

    // APB phase decode
    assign setup_ph = psel_i && !penable_i;
    assign wr_acc   = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;                // Zero wait states

    // Address decode and read data for the current address
    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = '0;
        unique case (paddr_i)
            SPP_ADDR_PAT_A: rd_mux[7:0] = {latch_r[0], alt_r[0]};
            SPP_ADDR_PAT_B: rd_mux[7:0] = {latch_r[1], alt_r[1]};
            SPP_ADDR_CTRL:  rd_mux[8:0] = pattern_control_reg;
            SPP_ADDR_FUNC:  rd_mux[7:0] = port_func_ctrl_r;
            SPP_ADDR_PDATA: rd_mux[7:0] = port_data_r;
            default:        addr_ok     = 1'b0;   // Unmapped
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
        end else if (setup_ph) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
            pslverr_o <= !addr_ok;
        end
    end

    // Control, function and port data registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pattern_control_reg <= SPP_CTRL_RST;
            port_func_ctrl_r    <= SPP_FUNC_RST;
            port_data_r         <= SPP_PDATA_RST;
        end else if (wr_acc) begin
            if (paddr_i == SPP_ADDR_CTRL) begin
                pattern_control_reg <= pwdata_i[8:0];
            end
            if (paddr_i == SPP_ADDR_FUNC) begin
                port_func_ctrl_r <= pwdata_i[7:0];
            end
            if (paddr_i == SPP_ADDR_PDATA) begin
                port_data_r <= pwdata_i[7:0];
            end
        end
    end

    // 8-bit timer edges count only with toggle inversion enabled
    assign trig_src = {compare_upper_b_match_i,
                       compare_upper_a_match_i,
                       timer_toggle_ff1_i && toggle_invert_en_i,
                       timer_toggle_ff0_i && toggle_invert_en_i};

    // Remember trigger levels for edge detection
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            trig_prev_r <= 4'h0;
        end else begin
            trig_prev_r <= trig_src;
        end
    end

    assign trig_rise = trig_src & ~trig_prev_r;

    // Channel A trigger select
    always_comb begin
        unique case (pattern_control_reg.trig_a_sel)
            SPP_TRIG_T0: trig_a_rise = trig_rise[0];
            SPP_TRIG_T1: trig_a_rise = trig_rise[1];
            SPP_TRIG_T5: trig_a_rise = trig_rise[3];
            default:     trig_a_rise = 1'b0;                 // Illegal code
        endcase
    end

    // Channel B fires only on a 16-bit upper compare match
    assign step_trig = {pattern_control_reg.trig_b_sel ?
                        trig_rise[3] : trig_rise[2],
                        trig_a_rise};

    assign wr_pat[0] = wr_acc && (paddr_i == SPP_ADDR_PAT_A);
    assign wr_pat[1] = wr_acc && (paddr_i == SPP_ADDR_PAT_B);

    // Independent channels, one per port nibble
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [7:0] ring_nxt;              // Ring shift result
        assign ring_nxt = spp_ring_step(latch_r[c], alt_r[c],
                                        chan_cfg[c].dir_reverse);

        // Output latch: cleared by reset, shifted or written
        always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
                latch_r[c] <= SPP_LATCH_RST;
            end else if (wr_pat[c] && !chan_cfg[c].pattern_sel) begin
                latch_r[c] <= pwdata_i[SPP_LATCH_LSB+:4];
            end else if (step_trig[c]) begin
                if (chan_cfg[c].excite_sel) begin
                    latch_r[c] <= ring_nxt[SPP_LATCH_LSB+:4];
                end else begin
                    latch_r[c] <= spp_rot4(latch_r[c],
                                  chan_cfg[c].dir_reverse);
                end
            end
        end

        // Alternate nibble: no reset, write wins over the shift
        always_ff @(posedge clk_sys_i) begin
            if (wr_pat[c]) begin
                alt_r[c] <= pwdata_i[SPP_ALT_LSB+:4];
            end else if (step_trig[c] && chan_cfg[c].excite_sel) begin
                alt_r[c] <= ring_nxt[SPP_ALT_LSB+:4];
            end
        end

        // Latch holds without trigger or write
        AST_LATCH_HOLD: assert property (@(posedge clk_sys_i)
            disable iff (!rst_n_i) !step_trig[c] && !wr_pat[c]
            |=> $stable(latch_r[c]))
            else $error("latch moved without trigger");

        // Normal 1/2 step rotation
        AST_ROT_UP: assert property (@(posedge clk_sys_i)
            disable iff (!rst_n_i) step_trig[c] && !wr_pat[c] &&
            !chan_cfg[c].excite_sel && !chan_cfg[c].dir_reverse
            |=> latch_r[c] == {$past(latch_r[c][2:0]),
                               $past(latch_r[c][3])})
            else $error("normal rotation wrong");

        // Reverse 1/2 step rotation
        AST_ROT_DOWN: assert property (@(posedge clk_sys_i)
            disable iff (!rst_n_i) step_trig[c] && !wr_pat[c] &&
            !chan_cfg[c].excite_sel && chan_cfg[c].dir_reverse
            |=> latch_r[c] == {$past(latch_r[c][0]),
                               $past(latch_r[c][3:1])})
            else $error("reverse rotation wrong");

        // Alternate untouched by 1/2 step shifts
        AST_ALT_IGNORED: assert property (@(posedge clk_sys_i)
            disable iff (!rst_n_i)
            step_trig[c] && !wr_pat[c] && !chan_cfg[c].excite_sel
            |=> $stable(alt_r[c]))
            else $error("alternate changed in 1/2 step");

        // Normal ring: latch takes alternate, alternate takes latch up
        AST_RING_UP: assert property (@(posedge clk_sys_i)
            disable iff (!rst_n_i) step_trig[c] && !wr_pat[c] &&
            chan_cfg[c].excite_sel && !chan_cfg[c].dir_reverse
            |=> latch_r[c] == $past(alt_r[c]) &&
            alt_r[c] == {$past(latch_r[c][2:0]), $past(latch_r[c][3])})
            else $error("normal ring shift wrong");

        // Reverse ring: alternate takes latch, latch takes alternate down
        AST_RING_DOWN: assert property (@(posedge clk_sys_i)
            disable iff (!rst_n_i) step_trig[c] && !wr_pat[c] &&
            chan_cfg[c].excite_sel && chan_cfg[c].dir_reverse
            |=> alt_r[c] == $past(latch_r[c]) &&
            latch_r[c] == {$past(alt_r[c][0]), $past(alt_r[c][3:1])})
            else $error("reverse ring shift wrong");

        // Latch writes blocked in pattern operation
        AST_PAT_BLOCK: assert property (@(posedge clk_sys_i)
            disable iff (!rst_n_i) wr_pat[c] && chan_cfg[c].pattern_sel
            && !step_trig[c] |=> $stable(latch_r[c]) &&
            alt_r[c] == $past(pwdata_i[3:0]))
            else $error("pattern write reached latch");

        // Reset clears the latch
        AST_LATCH_RST: assert property (@(posedge clk_sys_i)
            !rst_n_i |=> latch_r[c] == SPP_LATCH_RST)
            else $error("latch not cleared by reset");
    end

    // Per-pin choice between pattern output and port data
    for (genvar b = 0; b < 8; b++) begin : g_pin
        assign port_nxt[b] = port_func_ctrl_r[b] ?
                             latch_r[b/4][b%4] : port_data_r[b];
    end

    // Port pins driven from a register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            shared_port_o <= 8'h00;
        end else begin
            shared_port_o <= port_nxt;
        end
    end

    // Pin follows its mux one cycle later
    AST_PORT_MUX: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) 1'b1 |=> shared_port_o == $past(port_nxt))
        else $error("port pin mismatch");

    // Channel B strobe needs a 16-bit match edge
    AST_TRIG_B: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) step_trig[1] |->
        (compare_upper_a_match_i || compare_upper_b_match_i))
        else $error("channel B shifted without match");

    // 8-bit timer edges ignored without inversion enable
    AST_T8_GATE: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) !toggle_invert_en_i &&
        pattern_control_reg.trig_a_sel != SPP_TRIG_T5 |-> !step_trig[0])
        else $error("8-bit trigger without inversion");

endmodule

// >>> bench/spp_motor_model.sv
// Stepper driver model that counts phase changes on channel A pins
`timescale 1ns/1ps
module spp_motor_model (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Phase windings
    input  wire logic [3:0]  phase_i,
    // Observed steps
    output logic      [15:0] steps_o
);
    logic [3:0] last_r;  // Winding drive seen last edge

    // Count every change of winding drive as one motor step
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            last_r  <= 4'h0;
            steps_o <= 16'h0;
        end else begin
            last_r <= phase_i;
            if (phase_i != last_r) begin
                steps_o <= steps_o + 16'h1;
            end
        end
    end
endmodule

// >>> bench/tb.sv
// Self-checking bench for the stepper pattern port
`timescale 1ns/1ps
module tb import spp_pkg::*;;
    logic        clk_sys_i, rst_n_i, psel, penable, pwrite;
    logic        pready, pslverr, er, inv_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  trig;   // ff0, ff1, timer4 match, timer5 match
    logic [7:0]  port, e;
    logic [15:0] steps, s0;
    int          fail_count, checked, cyc;

    // Free-running system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    spp_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .timer_toggle_ff0_i(trig[0]),
        .timer_toggle_ff1_i(trig[1]), .toggle_invert_en_i(inv_en),
        .compare_upper_a_match_i(trig[2]),
        .compare_upper_b_match_i(trig[3]), .shared_port_o(port));

    spp_motor_model motor (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .phase_i(port[3:0]), .steps_o(steps));

    // Compare one value and log a mismatch
    task automatic check(input string nm, input logic [31:0] x, g);
        checked++;
        if (x !== g) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, x, g);
        end
    endtask

    // One APB transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys_i);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    // Single-cycle trigger pulse, then let latch and port settle
    task automatic pulse(input int s);
        @(posedge clk_sys_i);
        trig[s] <= 1'h1;
        @(posedge clk_sys_i);
        trig[s] <= 1'h0;
        repeat (3) @(posedge clk_sys_i);
    endtask

    // Expected register after one shift: nibble rotate or 8-bit ring
    function automatic logic [7:0] nxt(input logic [7:0] v,
                                       input logic ring, rev);
        logic [7:0] r;
        logic [7:0] o;
        o = v;
        r = {v[7], v[3], v[6], v[2], v[5], v[1], v[4], v[0]};
        r = rev ? {r[0], r[7:1]} : {r[6:0], r[7]};
        if (ring) o = {r[7], r[5], r[3], r[1], r[6], r[4], r[2], r[0]};
        else o[7:4] = rev ? {v[4], v[7:5]} : {v[6:4], v[7]};
        return o;
    endfunction

    // Seed a register, then trigger n shifts and check each one
    task automatic run(input int s, input logic [11:0] a,
                       input logic [7:0] v, input logic ring, rev,
                       input int n);
        e = v;
        apb(1'h1, a, {24'h0, v});
        repeat (n) begin
            e = nxt(e, ring, rev);
            pulse(s);
            apb(1'h0, a, 32'h0);
            check("pattern", {24'h0, e}, rd);
        end
    endtask

    // Closing report and verdict
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {trig, inv_en, rst_n_i, fail_count, checked, cyc} = '0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        check("port", 32'h0, {24'h0, port});
        apb(1'h0, SPP_ADDR_PAT_A, 32'h0);
        check("latch_a", 32'h0, {28'h0, rd[7:4]});
        apb(1'h0, SPP_ADDR_PAT_B, 32'h0);
        check("latch_b", 32'h0, {28'h0, rd[7:4]});
        apb(1'h0, SPP_ADDR_CTRL, 32'h0);
        check("ctrl", {23'h0, SPP_CTRL_RST}, rd);
        apb(1'h0, 12'h200, 32'h0);
        check("slverr", 32'h1, {31'h0, er});
        // Give channel B's alternate nibble a known value
        apb(1'h1, SPP_ADDR_PAT_B, 32'h0);
        $display("test reset done");
        // Channel A 1-step from every timer source
        inv_en <= 1'h1;
        apb(1'h1, SPP_ADDR_FUNC, 32'hFF);
        s0 = steps;
        for (int c = 0; c < 3; c++) begin
            apb(1'h1, SPP_ADDR_CTRL, 32'(c << 6));
            run((c == 2) ? 3 : c, SPP_ADDR_PAT_A, 8'h10, 1'h0, 1'h0,
                4);
            pulse(2);
            apb(1'h0, SPP_ADDR_PAT_A, 32'h0);
            check("unselected", 32'h10, rd);
        end
        check("motor", 32'd13, {16'h0, steps - s0});
        $display("test one step done");
        // Reverse 2-step, alternate nibble left alone
        apb(1'h1, SPP_ADDR_CTRL, 32'h1);
        run(0, SPP_ADDR_PAT_A, 8'h35, 1'h0, 1'h1, 4);
        inv_en <= 1'h0;
        pulse(0);
        apb(1'h0, SPP_ADDR_PAT_A, 32'h0);
        check("blocked", 32'h35, rd);
        inv_en <= 1'h1;
        $display("test two step done");
        // Channel B from both 16-bit sources, A untouched; then channel A ring from timer 0
        apb(1'h1, SPP_ADDR_CTRL, 32'h0);
        run(2, SPP_ADDR_PAT_B, 8'h60, 1'h0, 1'h0, 4);
        apb(1'h0, SPP_ADDR_PAT_A, 32'h0);
        check("independent", 32'h35, rd);
        apb(1'h1, SPP_ADDR_CTRL, 32'h118);
        run(3, SPP_ADDR_PAT_B, 8'hC8, 1'h1, 1'h1,
            8);
        apb(1'h1, SPP_ADDR_CTRL, 32'h2);
        run(0, SPP_ADDR_PAT_A, 8'h37, 1'h1, 1'h0, 3);
        $display("test ring done");
        // Pattern mode: latch write blocked, shifts like the ring
        apb(1'h1, SPP_ADDR_PAT_A, 32'hC8);
        apb(1'h1, SPP_ADDR_CTRL, 32'h6);
        apb(1'h1, SPP_ADDR_PAT_A, 32'h0F);
        apb(1'h0, SPP_ADDR_PAT_A, 32'h0);
        check("pat_write", 32'hCF, rd);
        pulse(0);
        apb(1'h0, SPP_ADDR_PAT_A, 32'h0);
        check("pat_shift", {24'h0, nxt(8'hCF, 1'h1, 1'h0)}, rd);
        apb(1'h1, SPP_ADDR_CTRL, 32'h36);
        apb(1'h1, SPP_ADDR_PAT_B, 32'h0A);
        apb(1'h0, SPP_ADDR_PAT_B, 32'h0);
        check("pat_write_b", 32'hCA, rd);
        $display("test pattern done");
        // Per-pin selection between pattern and port data
        apb(1'h1, SPP_ADDR_PDATA, 32'hA5);
        apb(1'h0, SPP_ADDR_PAT_A, 32'h0);
        e[3:0] = rd[7:4];
        apb(1'h0, SPP_ADDR_PAT_B, 32'h0);
        e[7:4] = rd[7:4];
        for (int f = 0; f < 2; f++) begin
            apb(1'h1, SPP_ADDR_FUNC, f ? 32'h5A : 32'h0F);
            repeat (2) @(negedge clk_sys_i);
            check("port", {24'h0, (pwdata[7:0] & e) |
                  (~pwdata[7:0] & 8'hA5)}, {24'h0, port});
        end
        $display("test port select done");
        stop_test();
    end
endmodule
